// >>> shared/tcpp_map.svh
// constants of the timer compare / single-pulse / pwm block
// assumes a 16-bit up counter ticked by a cpu clock prescaler or an external clock
`ifndef TCPP_MAP_SVH
`define TCPP_MAP_SVH

// reset values
`define TCPP_CMP_RST     16'h8000
`define TCPP_CNT_RST     16'hFFFC
`define TCPP_PIN_RST     2'h0

// loads applied by the pulse and pwm modes
`define TCPP_CNT_LOAD    16'hFFFC
`define TCPP_CAP_LOAD    16'hFFFD

// clock divider select codes
`define TCPP_CC_DIV4     2'h0
`define TCPP_CC_DIV2     2'h1
`define TCPP_CC_DIV8     2'h2
`define TCPP_CC_EXT      2'h3

// prescaler masks: a tick falls where all masked bits are one
`define TCPP_PRE_DIV2    3'h1
`define TCPP_PRE_DIV4    3'h3
`define TCPP_PRE_DIV8    3'h7

`endif

// >>> shared/tcpp_pkg.sv
// types of the timer compare / single-pulse / pwm block
// constants live in tcpp_map.svh
package tcpp_pkg;

   typedef enum logic [1:0] {
      TCPP_NORMAL = 2'b00,
      TCPP_PULSE  = 2'b01,
      TCPP_PWM    = 2'b10
   } tcpp_mode_t;

endpackage

// >>> design/tcpp_sync.sv
// three-flop synchroniser with agreement filter for one pin
// assumes clk is the block clock and ce freezes it
`timescale 1ns/100ps
`default_nettype none

module tcpp_sync (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ce,
   input  wire logic pin,
   output var  logic level
);

   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   logic level_ff;

   // a change counts once the second and third stage agree
   wire logic agree = (s2_ff == s3_ff);

   always_ff @(posedge clk) begin
      if (rst) begin
         s1_ff    <= 1'b0;
         s2_ff    <= 1'b0;
         s3_ff    <= 1'b0;
         level_ff <= 1'b0;
      end else if (ce) begin
         s1_ff    <= pin;
         s2_ff    <= s1_ff;
         s3_ff    <= s2_ff;
         if (agree) begin
            level_ff <= s3_ff;
         end
      end
   end

   assign level = level_ff;

endmodule

`default_nettype wire

// >>> design/tcpp_top.sv
// 16-bit timer compare, forced output, single-pulse and pwm logic with its counter
// assumes software byte writes arrive as one-cycle strobes on clk; pins are asynchronous
//
// What this block does
// RULE_01 - high byte write inhibits compare until low
// RULE_02 - disabled pin ignores match; flag still sets
// RULE_03 - divide-by-2: match when counter equals compare
// RULE_04 - other clocks: match at compare plus one
// RULE_05 - force copies level, no flag; normal only
// RULE_06 - pulse mode: capture1 triggers, compare1 ends
// RULE_07 - trigger loads FFFC, level2, flag1, FFFD
// RULE_08 - capture flag clears: status read, low access
// RULE_09 - pulse mode compare1 match drives level1
// RULE_10 - software programs duration minus five ticks
// RULE_11 - pulse mode never sets compare flag1
// RULE_12 - both mode bits set means pwm only
// RULE_13 - pulse mode: capture2 still works normally
// RULE_14 - pulse mode: compare2 flags, never drives pin
// RULE_15 - equal levels give constant pin one
// RULE_16 - pwm compare writes take effect at period end
// RULE_17 - pwm: match1 level1, match2 level2 plus reload
// RULE_18 - pwm high pulse spans compare2 minus compare1
// RULE_19 - pwm never sets either compare flag
// RULE_20 - pwm period end sets capture flag1
// RULE_21 - pwm disconnects capture1; capture2 still works
// RULE_22 - flash variant holds flag two bits at zero
// RULE_23 - compare registers reset to 8000h
// RULE_24 - both select bits one picks external clock
// RULE_25 - counter wraps through FFFFh after FFFCh load
`timescale 1ns/100ps
`default_nettype none
`include "tcpp_map.svh"

module tcpp_top
   import tcpp_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic [7:0]  cpu_wdata,
   input  wire logic [1:0]  cmp_high_wr,
   input  wire logic [1:0]  cmp_low_wr,
   input  wire logic [1:0]  cmp_low_rd,
   input  wire logic [1:0]  cap_low_acc,
   input  wire logic        status_rd,
   input  wire logic [1:0]  clock_divider_select,
   input  wire logic        ext_edge_rising,
   input  wire logic        capture_edge_one,
   input  wire logic        capture_edge_two,
   input  wire logic        single_pulse_select,
   input  wire logic        pwm_select,
   input  wire logic [1:0]  compare_pin_enable,
   input  wire logic [1:0]  compare_output_level,
   input  wire logic [1:0]  force_output_level,
   input  wire logic        flash_variant,
   input  wire logic        capture_input_pin_one,
   input  wire logic        capture_input_pin_two,
   input  wire logic        ext_clock_pin,
   output var  logic [1:0]  compare_output_pin,
   output var  logic [1:0]  compare_pin_owned,
   output var  logic [15:0] counter_value,
   output var  logic [15:0] compare_value_one,
   output var  logic [15:0] compare_value_two,
   output var  logic [15:0] capture_value_one,
   output var  logic [15:0] capture_value_two,
   output var  logic [1:0]  compare_match_flag,
   output var  logic [1:0]  capture_event_flag
);

   logic [2:0]        pre_ff;
   logic [15:0]       cnt_ff;
   logic              upd_ff;
   logic [1:0][15:0]  buf_ff;
   logic [1:0][15:0]  act_ff;
   logic [1:0]        inh_ff;
   logic [1:0]        cmp_flag_ff;
   logic [1:0]        cmp_arm_ff;
   logic [1:0]        cap_flag_ff;
   logic [1:0]        cap_arm_ff;
   logic [15:0]       cap1_ff;
   logic [15:0]       cap2_ff;
   logic [1:0]        pin_ff;
   logic [1:0]        own_ff;
   logic              cap1_prev_ff;
   logic              cap2_prev_ff;
   logic              ext_prev_ff;

   wire logic cap1_lvl;
   wire logic cap2_lvl;
   wire logic ext_lvl;

   tcpp_sync u_sync_cap1 (.clk(clk), .rst(rst), .ce(ce), .pin(capture_input_pin_one),
                          .level(cap1_lvl));
   tcpp_sync u_sync_cap2 (.clk(clk), .rst(rst), .ce(ce), .pin(capture_input_pin_two),
                          .level(cap2_lvl));
   tcpp_sync u_sync_ext  (.clk(clk), .rst(rst), .ce(ce), .pin(ext_clock_pin),
                          .level(ext_lvl));

   // RULE_12 pwm wins over pulse
   wire tcpp_mode_t mode = pwm_select          ? TCPP_PWM   :
                           single_pulse_select ? TCPP_PULSE : TCPP_NORMAL;
   wire logic is_norm  = (mode == TCPP_NORMAL);
   wire logic is_pulse = (mode == TCPP_PULSE);
   wire logic is_pwm   = (mode == TCPP_PWM);

   // RULE_24 clock source selection
   wire logic sel_div2 = (clock_divider_select == `TCPP_CC_DIV2);
   wire logic sel_div4 = (clock_divider_select == `TCPP_CC_DIV4);
   wire logic sel_div8 = (clock_divider_select == `TCPP_CC_DIV8);
   wire logic sel_ext  = (clock_divider_select == `TCPP_CC_EXT);
   wire logic ext_edge = (ext_lvl != ext_prev_ff) && (ext_lvl == ext_edge_rising);
   wire logic tick = (sel_div2 && ((pre_ff & `TCPP_PRE_DIV2) == `TCPP_PRE_DIV2)) ||
                     (sel_div4 && ((pre_ff & `TCPP_PRE_DIV4) == `TCPP_PRE_DIV4)) ||
                     (sel_div8 && ((pre_ff & `TCPP_PRE_DIV8) == `TCPP_PRE_DIV8)) ||
                     (sel_ext && ext_edge);

   // RULE_21 capture pin one is ignored in pwm
   wire logic edge1 = (cap1_lvl != cap1_prev_ff) && (cap1_lvl == capture_edge_one) && !is_pwm;
   wire logic edge2 = (cap2_lvl != cap2_prev_ff) && (cap2_lvl == capture_edge_two);
   // RULE_06 capture one is the trigger in pulse mode
   wire logic trig = edge1 && is_pulse;

   wire logic [1:0]        m_evt;
   wire logic [1:0][15:0]  target;
   wire logic [1:0][15:0]  nxt_buf;
   wire logic [1:0][15:0]  nxt_act;
   wire logic [1:0]        nxt_inh;
   wire logic [1:0]        cmp_set;
   wire logic [1:0]        cmp_clr;
   wire logic [1:0]        cap_set;
   wire logic [1:0]        cap_clr;
   wire logic [1:0]        nxt_pin;

   wire logic period_end = is_pwm && m_evt[1];

   genvar i;
   for (i = 0; i < 2; i++) begin : g_ch
      assign nxt_buf[i] = {cmp_high_wr[i] ? cpu_wdata : buf_ff[i][15:8],
                           cmp_low_wr[i]  ? cpu_wdata : buf_ff[i][7:0]};
      // RULE_16 pwm holds new values until the period ends
      assign nxt_act[i] = (!is_pwm || period_end) ? nxt_buf[i] : act_ff[i];
      // RULE_01 inhibit between high and low byte writes
      assign nxt_inh[i] = cmp_high_wr[i] ? 1'b1 : (cmp_low_wr[i] ? 1'b0 : inh_ff[i]);
      // RULE_03 RULE_04 match point depends on the clock rate
      assign target[i]  = sel_div2 ? act_ff[i] : 16'(act_ff[i] + 16'h0001);
      assign m_evt[i]   = upd_ff && (cnt_ff == target[i]) && !inh_ff[i];
      // RULE_08 second step of the two-step clear
      assign cmp_clr[i] = cmp_arm_ff[i] && (cmp_low_wr[i] || cmp_low_rd[i]);
      assign cap_clr[i] = cap_arm_ff[i] && cap_low_acc[i];
   end

   // RULE_11 RULE_19 RULE_22 compare flag sources per mode
   assign cmp_set[0] = m_evt[0] && is_norm;
   assign cmp_set[1] = m_evt[1] && !is_pwm && !flash_variant;
   // RULE_07 RULE_20 capture flag one sources
   assign cap_set[0] = edge1 || period_end;
   // RULE_13 RULE_22 capture two works in every mode
   assign cap_set[1] = edge2 && !flash_variant;

   // RULE_02 RULE_05 RULE_09 RULE_15 RULE_17 RULE_18 pin one level selection
   wire logic pin0_norm = force_output_level[0] || m_evt[0];
   wire logic pin0_hit  = is_norm ? pin0_norm : (trig || m_evt[0] || (is_pwm && m_evt[1]));
   wire logic pin0_val  = (trig || (is_pwm && m_evt[1])) ? compare_output_level[1] :
                          compare_output_level[0];
   assign nxt_pin[0] = (compare_pin_enable[0] && pin0_hit) ? pin0_val : pin_ff[0];
   // RULE_14 compare two drives its pin only in normal mode
   assign nxt_pin[1] = (compare_pin_enable[1] && is_norm &&
                        (force_output_level[1] || m_evt[1])) ? compare_output_level[1] :
                       pin_ff[1];

   // RULE_07 RULE_17 RULE_25 counter load and wrap
   wire logic        cnt_load = trig || period_end;
   wire logic [15:0] nxt_cnt  = cnt_load ? `TCPP_CNT_LOAD :
                                (tick ? 16'(cnt_ff + 16'h0001) : cnt_ff);

   // set wins over clear on every flag
   wire logic [1:0] nxt_cmp_flag = (cmp_set | (cmp_flag_ff & ~cmp_clr)) &
                                   {~flash_variant, 1'b1};
   wire logic [1:0] nxt_cap_flag = (cap_set | (cap_flag_ff & ~cap_clr)) &
                                   {~flash_variant, 1'b1};
   // RULE_08 first step arms on a status read while set
   wire logic [1:0] nxt_cmp_arm = (status_rd ? cmp_flag_ff : cmp_arm_ff) & ~cmp_clr;
   wire logic [1:0] nxt_cap_arm = (status_rd ? cap_flag_ff : cap_arm_ff) & ~cap_clr;

   wire logic [15:0] nxt_cap1 = trig ? `TCPP_CAP_LOAD : (edge1 ? cnt_ff : cap1_ff);
   wire logic [15:0] nxt_cap2 = cap_set[1] ? cnt_ff : cap2_ff;

   always_ff @(posedge clk) begin
      if (rst) begin
         pre_ff <= 3'h0;
         cnt_ff <= `TCPP_CNT_RST;
         upd_ff <= 1'b0;
      end else if (ce) begin
         pre_ff <= 3'(pre_ff + 3'h1);
         cnt_ff <= nxt_cnt;
         upd_ff <= cnt_load || tick;
      end
   end

   // RULE_23 compare registers start at mid-scale
   always_ff @(posedge clk) begin
      if (rst) begin
         buf_ff <= {2{`TCPP_CMP_RST}};
         act_ff <= {2{`TCPP_CMP_RST}};
         inh_ff <= 2'h0;
      end else if (ce) begin
         buf_ff <= nxt_buf;
         act_ff <= nxt_act;
         inh_ff <= nxt_inh;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cmp_flag_ff <= 2'h0;
         cmp_arm_ff  <= 2'h0;
         cap_flag_ff <= 2'h0;
         cap_arm_ff  <= 2'h0;
         cap1_ff     <= 16'h0000;
         cap2_ff     <= 16'h0000;
      end else if (ce) begin
         cmp_flag_ff <= nxt_cmp_flag;
         cmp_arm_ff  <= nxt_cmp_arm;
         cap_flag_ff <= nxt_cap_flag;
         cap_arm_ff  <= nxt_cap_arm;
         cap1_ff     <= nxt_cap1;
         cap2_ff     <= nxt_cap2;
      end
   end

   // pin latch is held low through reset
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_ff       <= `TCPP_PIN_RST;
         own_ff       <= 2'h0;
         cap1_prev_ff <= 1'b0;
         cap2_prev_ff <= 1'b0;
         ext_prev_ff  <= 1'b0;
      end else if (ce) begin
         pin_ff       <= nxt_pin;
         own_ff       <= compare_pin_enable;
         cap1_prev_ff <= cap1_lvl;
         cap2_prev_ff <= cap2_lvl;
         ext_prev_ff  <= ext_lvl;
      end
   end

   assign compare_output_pin = pin_ff;
   assign compare_pin_owned  = own_ff;
   assign counter_value      = cnt_ff;
   assign compare_value_one  = buf_ff[0];
   // in the flash variant this readback is undefined to software
   assign compare_value_two  = buf_ff[1];
   assign capture_value_one  = cap1_ff;
   assign capture_value_two  = cap2_ff;
   assign compare_match_flag = cmp_flag_ff;
   assign capture_event_flag = cap_flag_ff;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_inhibit_blocks_match: assert property ( // RULE_01
      inh_ff[0] |=> !$rose(cmp_flag_ff[0]))
      else $error("compare one matched while inhibited");
   a_disabled_pin_hold: assert property ( // RULE_02
      ce && !compare_pin_enable[0] |=> $stable(pin_ff[0]))
      else $error("disabled compare pin changed");
   // the flag edge is never a tick edge, so the counter still shows the match value
   a_div2_match_point: assert property ( // RULE_03
      $rose(cmp_flag_ff[0]) && sel_div2 |-> cnt_ff == act_ff[0])
      else $error("divide-by-2 match at wrong count");
   a_slow_match_point: assert property ( // RULE_04
      $rose(cmp_flag_ff[1]) && !sel_div2 |-> cnt_ff == 16'(act_ff[1] + 16'h0001))
      else $error("slow clock match at wrong count");
   a_force_copies_level: assert property ( // RULE_05
      ce && is_norm && force_output_level[0] && compare_pin_enable[0]
      |=> pin_ff[0] == $past(compare_output_level[0]))
      else $error("forced level not copied");
   a_pulse_trigger_load: assert property ( // RULE_07
      ce && trig
      |=> cnt_ff == `TCPP_CNT_LOAD && cap1_ff == `TCPP_CAP_LOAD && cap_flag_ff[0])
      else $error("pulse trigger loads wrong");
   a_cap_clear_steps: assert property ( // RULE_08
      $fell(cap_flag_ff[0]) |-> $past(cap_arm_ff[0] && cap_low_acc[0]))
      else $error("capture flag cleared without two steps");
   a_pwm_no_cmp_flag: assert property ( // RULE_19
      ce && is_pwm && cmp_flag_ff == 2'h0 |=> cmp_flag_ff == 2'h0)
      else $error("compare flag set in pwm");
   a_pwm_period_reload: assert property ( // RULE_17
      ce && period_end |=> cnt_ff == `TCPP_CNT_LOAD ##0 cap_flag_ff[0])
      else $error("pwm period end missed reload");
   a_flash_flags_zero: assert property ( // RULE_22
      ce && flash_variant |=> !cmp_flag_ff[1] && !cap_flag_ff[1])
      else $error("flash variant flag two set");

   c_pulse_trigger: cover property (ce && trig);
   c_pwm_period: cover property (ce && period_end);
   c_forced_output: cover property (ce && is_norm && force_output_level[0]);
   c_capture_two: cover property (ce && cap_set[1]);

endmodule

`default_nettype wire

// >>> test/tcpp_far_side.sv
// far-side model: capture input pins and external clock pin of the timer
// assumes trigger requests arrive as one-cycle pulses on clk
`timescale 1ns/100ps
`default_nettype none

module tcpp_far_side (
   input  wire logic clk,
   input  wire logic ext_run,
   input  wire logic trig_one,
   input  wire logic trig_two,
   output var  logic capture_input_pin_one,
   output var  logic capture_input_pin_two,
   output var  logic ext_clock_pin
);
   logic [3:0] div_ff = 4'h0;
   logic [3:0] one_ff = 4'h0;
   logic [3:0] two_ff = 4'h0;

   // capture pulses last 15 cycles so the synchroniser always sees them
   always_ff @(posedge clk) begin
      div_ff <= div_ff + 4'h1;
      one_ff <= trig_one ? 4'hF : one_ff - {3'h0, |one_ff};
      two_ff <= trig_two ? 4'hF : two_ff - {3'h0, |two_ff};
   end

   // external clock source
   // period of 16 cpu cycles; stands low while not selected
   always_comb begin
      ext_clock_pin         = ext_run & div_ff[3];
      capture_input_pin_one = |one_ff;
      capture_input_pin_two = |two_ff;
   end
endmodule
`default_nettype wire

// >>> test/tb.sv
// testbench of the timer compare, single-pulse and pwm block
// assumes the far-side model drives the capture and external clock pins
`timescale 1ns/100ps
`default_nettype none
`include "tcpp_map.svh"

module tb;
   logic        clk, rst, ce, status_rd, spm, pwm, flash, ext_run, trig_one, trig_two;
   logic [7:0]  wdata;
   logic [1:0]  hwr, lwr, lrd, cacc, cc, en, lvl, frc;
   logic [1:0]  pin, cmpf, capf, own;
   logic [15:0] cnt, cv1, cv2, cap_v1, cap_v2;
   wire  logic  cap1, cap2, extp;
   wire  logic [5:0] obs = {capf, cmpf, pin};
   int          fail_count, n_compared, t0, lows;
   int          cyc = 0;
   logic [1:0]  ccs [4] = '{`TCPP_CC_DIV2, `TCPP_CC_DIV4, `TCPP_CC_DIV8, `TCPP_CC_EXT};

   tcpp_top tcpp_top_inst (.clk(clk), .rst(rst), .ce(ce), .cpu_wdata(wdata),
      .cmp_high_wr(hwr), .cmp_low_wr(lwr), .cmp_low_rd(lrd), .cap_low_acc(cacc),
      .status_rd(status_rd), .clock_divider_select(cc), .ext_edge_rising(1'b1),
      .capture_edge_one(1'b1), .capture_edge_two(1'b1), .single_pulse_select(spm),
      .pwm_select(pwm), .compare_pin_enable(en), .compare_output_level(lvl),
      .force_output_level(frc), .flash_variant(flash), .capture_input_pin_one(cap1),
      .capture_input_pin_two(cap2), .ext_clock_pin(extp), .compare_output_pin(pin),
      .compare_pin_owned(own), .counter_value(cnt), .compare_value_one(cv1),
      .compare_value_two(cv2), .capture_value_one(cap_v1), .capture_value_two(cap_v2),
      .compare_match_flag(cmpf), .capture_event_flag(capf));

   tcpp_far_side tcpp_far_side_inst (.clk(clk), .ext_run(ext_run), .trig_one(trig_one),
      .trig_two(trig_two), .capture_input_pin_one(cap1), .capture_input_pin_two(cap2),
      .ext_clock_pin(extp));

   always #2 clk = ~clk;

   task print_verdict;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // the whole run needs about a thousand cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         print_verdict();
      end
   end

   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wt(input int b, input logic v, input int lim);
      int n;
      n = 0;
      @(negedge clk);
      while (obs[b] !== v && n < lim) begin
         @(negedge clk);
         n++;
      end
      chk("wait bit", {15'h0, v}, {15'h0, obs[b]});
   endtask

   task do_reset;
      @(negedge clk);
      rst = 1'b1;
      repeat (16) @(negedge clk);
      rst = 1'b0;
   endtask

   task strobe(input logic hi, input logic [1:0] ch, input logic [7:0] d);
      @(negedge clk);
      wdata = d;
      if (hi) hwr = ch;
      else lwr = ch;
      @(negedge clk);
      hwr = 2'h0;
      lwr = 2'h0;
   endtask

   task wr_cmp(input logic [1:0] ch, input logic [15:0] v);
      strobe(1'b1, ch, v[15:8]);
      strobe(1'b0, ch, v[7:0]);
   endtask

   task acc(input logic st, input logic [1:0] rd, input logic [1:0] ca);
      @(negedge clk);
      status_rd = st;
      lrd = rd;
      cacc = ca;
      @(negedge clk);
      status_rd = 1'b0;
      lrd = 2'h0;
      cacc = 2'h0;
   endtask

   initial begin
      clk = 1'b0; rst = 1'b1; status_rd = 1'b0; spm = 1'b0; pwm = 1'b0; flash = 1'b0;
      ext_run = 1'b0; trig_one = 1'b0; trig_two = 1'b0; wdata = 8'h00; hwr = 2'h0;
      lwr = 2'h0; lrd = 2'h0; cacc = 2'h0; cc = `TCPP_CC_DIV2; en = 2'h0; lvl = 2'h0;
      frc = 2'h0; fail_count = 0; n_compared = 0; ce = 1'b1; lows = 0;
      do_reset();
      chk("cmp one rst", `TCPP_CMP_RST, cv1);
      chk("cmp two rst", `TCPP_CMP_RST, cv2);
      chk("counter rst", `TCPP_CNT_RST, cnt);
      chk("pins flags rst", 16'h0000, {10'h0, obs});
      ce = 1'b0;
      repeat (10) @(negedge clk);
      chk("frozen counter", `TCPP_CNT_RST, cnt);
      ce = 1'b1;
      for (int i = 0; i < 4; i++) begin
         do_reset();
         cc = ccs[i];
         ext_run = (i == 3);
         flash = (i == 2);
         en = 2'h1;
         lvl = 2'h3;
         wr_cmp(2'h1, 16'h0006);
         wr_cmp(2'h2, 16'h0006);
         wt(2, 1'b1, 600);
         chk("match count", 16'h0006 + {15'h0, i != 0}, cnt);
         chk("pin one", 16'h0001, {15'h0, pin[0]});
         chk("flag two", {15'h0, i != 2}, {15'h0, cmpf[1]});
         chk("pin two", 16'h0000, {15'h0, pin[1]});
         chk("pin owned", {14'h0, en}, {14'h0, own});
      end
      ext_run = 1'b0;
      flash = 1'b0;
      do_reset();
      cc = `TCPP_CC_DIV2;
      strobe(1'b1, 2'h1, 8'h00);
      repeat (60) @(negedge clk);
      chk("inhibited", 16'h0000, {15'h0, cmpf[0]});
      strobe(1'b0, 2'h1, 8'h40);
      wt(2, 1'b1, 200);
      chk("late match", 16'h0040, cnt);
      acc(1'b0, 2'h1, 2'h0);
      @(negedge clk);
      chk("no arm", 16'h0001, {15'h0, cmpf[0]});
      acc(1'b1, 2'h0, 2'h0);
      acc(1'b0, 2'h1, 2'h0);
      @(negedge clk);
      chk("cleared", 16'h0000, {15'h0, cmpf[0]});
      // pin is high after the match, so forcing a low level shows the copy
      frc = 2'h1;
      lvl = 2'h0;
      repeat (4) @(negedge clk);
      chk("forced", 16'h0000, {14'h0, cmpf[0], pin[0]});
      spm = 1'b1;
      lvl = 2'h1;
      repeat (4) @(negedge clk);
      chk("force in pulse", 16'h0000, {15'h0, pin[0]});
      frc = 2'h0;
      do_reset();
      en = 2'h3;
      lvl = 2'h2;
      wr_cmp(2'h1, 16'h0020);
      wr_cmp(2'h2, 16'h0010);
      trig_one = 1'b1;
      @(negedge clk);
      trig_one = 1'b0;
      wt(4, 1'b1, 40);
      chk("trig capture", `TCPP_CAP_LOAD, cap_v1);
      chk("trig counter", `TCPP_CNT_LOAD, cnt);
      chk("trig pin", 16'h0001, {15'h0, pin[0]});
      trig_two = 1'b1;
      @(negedge clk);
      trig_two = 1'b0;
      wt(5, 1'b1, 40);
      // capture lands six cycles after the FFFC load: two or three ticks later
      chk("capture two", 16'h0001, {15'h0, cap_v2 >= 16'hFFFE});
      wt(3, 1'b1, 200);
      chk("pulse pin two", 16'h0000, {15'h0, pin[1]});
      wt(0, 1'b0, 200);
      chk("pulse end", 16'h0020, cnt);
      chk("pulse flag one", 16'h0000, {15'h0, cmpf[0]});
      acc(1'b1, 2'h0, 2'h0);
      acc(1'b0, 2'h0, 2'h1);
      @(negedge clk);
      chk("capture cleared", 16'h0000, {15'h0, capf[0]});
      spm = 1'b0;
      do_reset();
      en = 2'h1;
      lvl = 2'h1;
      wr_cmp(2'h1, 16'h0010);
      wr_cmp(2'h2, 16'h0020);
      spm = 1'b1;
      pwm = 1'b1;
      wt(0, 1'b1, 200);
      chk("pwm rise", 16'h0010, cnt);
      t0 = cyc;
      wr_cmp(2'h2, 16'h0028);
      wt(0, 1'b0, 200);
      chk("pwm high", (16'h0020 - 16'h0010) << 1, 16'(cyc - t0));
      chk("pwm reload", `TCPP_CNT_LOAD, cnt);
      chk("pwm flags", 16'h0004, {13'h0, capf[0], cmpf});
      wt(0, 1'b1, 200);
      t0 = cyc;
      wt(0, 1'b0, 200);
      chk("pwm high new", (16'h0028 - 16'h0010) << 1, 16'(cyc - t0));
      lvl = 2'h3;
      wt(0, 1'b1, 200);
      repeat (120) begin
         @(negedge clk);
         if (pin[0] !== 1'b1) lows++;
      end
      chk("steady pin", 16'h0000, 16'(lows));
      print_verdict();
   end
endmodule
`default_nettype wire
